// file: rtl/lpc_defs.vh
/*
 * Constants for the link protocol control register bank: bus offsets,
 * field positions, masks, reset value and cycle timer counts.
 * Assumes inclusion by bare name from design files of this block only.
 */
`ifndef LPC_DEFS_VH
`define LPC_DEFS_VH

// Register byte offsets
`define LPC_SET_OFF 12'h0_E0
`define LPC_CLR_OFF 12'h0_E4
`define LPC_STAT_OFF 12'h0_F0

// Control field positions
`define LPC_ROLL_SEL_BIT 22
`define LPC_GEN_EN_BIT 21
`define LPC_OFS_EN_BIT 20
`define LPC_PHY_ACC_BIT 10
`define LPC_SID_ACC_BIT 9
`define LPC_SYNC_FRC_BIT 6

// Implemented, settable and clearable bits
`define LPC_IMPL_MASK 32'h0070_0640
`define LPC_SET_MASK 32'h0070_0640
`define LPC_CLR_MASK 32'h0070_0600
`define LPC_CTRL_RESET 32'h0000_0000

// Status field positions
`define LPC_STAT_OFS_LSB 0
`define LPC_STAT_OVL_BIT 16
`define LPC_STAT_EXT_BIT 17

// Cycle timer: ticks of the 24.576 MHz offset clock per 125 us cycle
`define LPC_CYCLE_TICKS 12'h0_C00
`define LPC_OFS_W 12

// Isochronous receive contexts served
`define LPC_NUM_IR_CTX 4

// AXI responses
`define LPC_RESP_OKAY 2'h0
`define LPC_RESP_DECERR 2'h3

`endif

// file: rtl/lpc_sync2.v
/*
 * Two-flop synchroniser with a rising edge pulse on the synchronised level.
 * Assumes an asynchronous level input and one clock with synchronous reset.
 */
`timescale 1ns/1ps

module lpc_sync2 (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Asynchronous level in
    input wire async_in,
    // Synchronised level and its rising edge
    output wire level_out,
    output wire rise_out
);

    reg meta_q;
    reg sync_q;
    reg prev_q;

    // First flop feeds only the second; edge looks at later stages
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_out = sync_q;
    assign rise_out = sync_q & ~prev_q;

endmodule // lpc_sync2

// file: rtl/lpc_link_ctrl.v
/*
 * Link protocol control register bank with set and clear images on
 * AXI4-Lite, plus the cycle timer offset counter it steers and the
 * receive gating levels it drives.
 * Control bits, alike at both images:
 *   22 rollover select, 21 cycle start generator enable,
 *   20 cycle offset count enable, 10 PHY packet accept,
 *   9 self-ID accept, 6 sync filter force (set only, reset clears).
 * Status image at F0h, read only: 11:0 cycle offset,
 * 16 overlong cycle event, 17 synchronised cycle pin level.
 * Writes there or to any unmapped address change nothing and answer
 * with a decode error; unmapped reads return zero with the same error.
 * Bus timing: a write lands one edge after both halves are held, and
 * read data stand from the same edge that takes the address.
 * Limitation: in external rollover mode the offset stops at the top
 * count until the pin edge arrives, so a dead pin freezes the timer.
 * A received cycle start reloads the offset only while not root.
 * Assumes an offset clock tick strobe and receive events from logic on
 * aclk, an external cycle pin from outside, and aresetn as global reset.
 */
// Our own choices: the AXI4-Lite slave port and the address map.
// What this block does
// - Reserved bits 31-23, 19-11, 8-7 and 5-0 of the link control register read as zero.
// - With rollover select at 1 the cycle timer rolls over on the external cycle input.
// - With rollover select at 0 the cycle timer rolls over after 3072 offset clock ticks.
// - With the generator enable at 1 a cycle start request is issued at every rollover.
// - With the generator enable at 0 received cycle starts resynchronise the timer.
// - The generator enable is cleared by hardware when the overlong cycle event is 1.
// - Sets of the generator enable are ignored while the overlong cycle event is 1.
// - The cycle offset advances on offset clock ticks only while its count enable is 1.
// - PHY packets are stored only with their accept bit at 1 and the request context on.
// - Self-identification packets are accepted while the self-ID accept bit is 1.
// - With sync filter force at 1 every receive context sees its tag-one filter at 1.
// - With sync filter force at 0 each context's tag-one filter follows software.
// - Sync filter force can only be set by software and only global reset clears it.
// - The register is reached at E0h to set and E4h to clear, both reading the same.
`timescale 1ns/1ps
`include "lpc_defs.vh"

module lpc_link_ctrl (
    // Clock and global reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Cycle timer inputs
    input wire offset_clk_tick,
    input wire external_cycle_input,
    input wire overlong_cycle_event,
    input wire rx_cycle_start,
    input wire [11:0] rx_cycle_offset,
    // Cycle timer outputs
    output reg [11:0] cycle_offset,
    output reg cycle_rollover,
    output reg cycle_start_request,
    // Receive gating
    input wire async_receive_request_enable,
    output wire phy_packet_store_enable,
    output wire self_id_accept,
    // Isochronous receive tag-one sync filter
    input wire [3:0] tag_one_sync_filter_sw,
    output wire [3:0] tag_one_sync_filter,
    output wire sync_filter_force
);

    // Control register and bus state
    reg [31:0] ctrl_q;
    reg [31:0] ctrl_d;
    reg aw_full_q;
    reg [11:0] aw_addr_q;
    reg w_full_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg [31:0] rd_data_d;
    reg [1:0] rd_resp_d;
    reg [11:0] ofs_d;
    reg roll_d;
    reg [31:0] stat_word;

    // Synchroniser outputs, write decode and control field views
    wire ext_level;
    wire ext_rise;
    wire do_write;
    wire wr_set;
    wire wr_clr;
    wire wr_hit;
    wire [31:0] byte_mask;
    wire [31:0] wr_bits;
    wire roll_sel;
    wire gen_en;
    wire ofs_en;
    wire ofs_at_top;
    wire ofs_step;

    // Field views of the control register
    assign roll_sel = ctrl_q[`LPC_ROLL_SEL_BIT];
    assign gen_en = ctrl_q[`LPC_GEN_EN_BIT];
    assign ofs_en = ctrl_q[`LPC_OFS_EN_BIT];

    // Top count and counting strobe shared by both rollover modes
    assign ofs_at_top = (cycle_offset == `LPC_CYCLE_TICKS - 12'h0_001);
    assign ofs_step = ofs_en & offset_clk_tick;

    // External cycle pin enters through two flops
    lpc_sync2 u_ext_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(external_cycle_input),
        .level_out(ext_level),
        .rise_out(ext_rise)
    );

    // Each channel is ready while its holding slot is empty
    assign s_axi_awready = ~aw_full_q;
    assign s_axi_wready = ~w_full_q;
    assign s_axi_arready = ~s_axi_rvalid;

    // Write fires once both halves are held and no response is pending
    assign do_write = aw_full_q & w_full_q & ~s_axi_bvalid;
    assign wr_set = do_write & (aw_addr_q == `LPC_SET_OFF);
    assign wr_clr = do_write & (aw_addr_q == `LPC_CLR_OFF);
    assign wr_hit = wr_set | wr_clr;

    // Byte strobes limit which bits a write may touch
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane = lane + 1)
        begin : g_lane
            assign byte_mask[lane * 8 +: 8] = {8{w_strb_q[lane]}};
        end
    endgenerate

    assign wr_bits = w_data_q & byte_mask;

    // Write channel holding slots and response
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_q <= 1'b0;
            aw_addr_q <= 12'h0_000;
            w_full_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `LPC_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && !aw_full_q)
            begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_full_q)
            begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wr_hit)
                    s_axi_bresp <= `LPC_RESP_OKAY;
                else
                    s_axi_bresp <= `LPC_RESP_DECERR; // Status is read-only
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Next control value from set and clear images and hardware events
    always @*
    begin
        ctrl_d = ctrl_q;
        if (wr_set)
            ctrl_d = ctrl_q | (wr_bits & `LPC_SET_MASK);
        if (wr_clr)
            ctrl_d = ctrl_q & ~(wr_bits & `LPC_CLR_MASK);
        // Event wins over any set, so the enable cannot return until it drops
        if (overlong_cycle_event)
            ctrl_d[`LPC_GEN_EN_BIT] = 1'b0;
        ctrl_d = ctrl_d & `LPC_IMPL_MASK;
    end

    // Control register; global reset alone clears the force bit
    always @(posedge aclk)
    begin
        if (!aresetn)
            ctrl_q <= `LPC_CTRL_RESET;
        else
            ctrl_q <= ctrl_d;
    end

    // Status word for the read-only image; live values, no snapshot
    always @*
    begin
        stat_word = 32'h0000_0000;
        stat_word[`LPC_STAT_OFS_LSB +: `LPC_OFS_W] = cycle_offset;
        stat_word[`LPC_STAT_OVL_BIT] = overlong_cycle_event;
        stat_word[`LPC_STAT_EXT_BIT] = ext_level;
    end

    // Read data mux; both images show the same contents
    always @*
    begin
        rd_data_d = 32'h0000_0000;
        rd_resp_d = `LPC_RESP_OKAY;
        case (s_axi_araddr)
            `LPC_SET_OFF, `LPC_CLR_OFF:
            begin
                rd_data_d = ctrl_q & `LPC_IMPL_MASK;
            end
            `LPC_STAT_OFF:
            begin
                rd_data_d = stat_word;
            end
            default:
            begin
                rd_resp_d = `LPC_RESP_DECERR;
            end
        endcase
    end

    // Read channel: data registered at the same edge that takes the address
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `LPC_RESP_OKAY;
        end
        else if (s_axi_arvalid && !s_axi_rvalid)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data_d;
            s_axi_rresp <= rd_resp_d;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Cycle offset next state: resync, then rollover, then count
    always @*
    begin
        ofs_d = cycle_offset;
        roll_d = 1'b0;
        if (!gen_en && rx_cycle_start)
        begin
            ofs_d = rx_cycle_offset;
        end
        else if (roll_sel)
        begin
            if (ext_rise)
            begin
                roll_d = 1'b1;
                ofs_d = 12'h0_000;
            end
            else if (ofs_step && !ofs_at_top)
            begin
                ofs_d = cycle_offset + 12'h0_001;
            end
        end
        else if (ofs_step)
        begin
            if (ofs_at_top)
            begin
                roll_d = 1'b1;
                ofs_d = 12'h0_000;
            end
            else
            begin
                ofs_d = cycle_offset + 12'h0_001;
            end
        end
    end

    // Offset counter; external mode waits at the top count for the pin
    always @(posedge aclk)
    begin
        if (!aresetn)
            cycle_offset <= 12'h0_000;
        else
            cycle_offset <= ofs_d;
    end

    // Rollover pulses stand one cycle; start request only while root
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cycle_rollover <= 1'b0;
            cycle_start_request <= 1'b0;
        end
        else
        begin
            cycle_rollover <= roll_d;
            cycle_start_request <= roll_d & gen_en;
        end
    end

    // Receive gating levels
    assign phy_packet_store_enable = ctrl_q[`LPC_PHY_ACC_BIT] & async_receive_request_enable;
    assign self_id_accept = ctrl_q[`LPC_SID_ACC_BIT];
    assign sync_filter_force = ctrl_q[`LPC_SYNC_FRC_BIT];

    // Force overrides software copy in every context, else it passes
    genvar ctx;
    generate
        for (ctx = 0; ctx < `LPC_NUM_IR_CTX; ctx = ctx + 1)
        begin : g_tag_one
            assign tag_one_sync_filter[ctx] = tag_one_sync_filter_sw[ctx] | sync_filter_force;
        end
    endgenerate

endmodule // lpc_link_ctrl

// file: tb/lpc_link_ctrl_monitor.sv
/* Checker for lpc_link_ctrl ports: cycle timer and receive gating.
   Assumes the bind below and the design's synchronous active low reset. */
`timescale 1ns/1ps
module lpc_link_ctrl_monitor (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Cycle timer
    input wire offset_clk_tick,
    input wire rx_cycle_start,
    input wire overlong_cycle_event,
    input wire [11:0] cycle_offset,
    input wire cycle_rollover,
    input wire cycle_start_request,
    // Receive gating
    input wire async_receive_request_enable,
    input wire phy_packet_store_enable,
    input wire [3:0] tag_one_sync_filter_sw,
    input wire [3:0] tag_one_sync_filter,
    input wire sync_filter_force
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Event held long enough to have cleared the enable
    sequence s_long_event;
        overlong_cycle_event [*3];
    endsequence
    // Offset moved neither by a load nor by a wrap
    sequence s_plain_step;
        $changed(cycle_offset) && cycle_offset != 12'h000 && !$past(rx_cycle_start);
    endsequence
    // Cycle timer
    a_start_on_roll: assert property (cycle_start_request |-> cycle_rollover)
        else $error("start request without rollover");
    a_roll_to_zero: assert property (cycle_rollover |-> cycle_offset == 12'h000)
        else $error("rollover with nonzero offset");
    a_offset_cause: assert property ($changed(cycle_offset) |->
        $past(offset_clk_tick) || $past(rx_cycle_start) || cycle_offset == 12'h000)
        else $error("offset moved without a cause");
    a_count_step: assert property (s_plain_step |-> cycle_offset == $past(cycle_offset) + 12'h001)
        else $error("offset step not one");
    a_gen_cleared: assert property (s_long_event |=> !cycle_start_request)
        else $error("start request during overlong event");
    // Receive gating, which the contexts rely on every cycle
    a_phy_gated: assert property (!async_receive_request_enable |-> !phy_packet_store_enable)
        else $error("phy store without context");
    a_force_all: assert property (sync_filter_force |-> tag_one_sync_filter == 4'hf)
        else $error("forced filter not all ones");
    a_follow_sw: assert property (!sync_filter_force |-> tag_one_sync_filter == tag_one_sync_filter_sw)
        else $error("filter not following software");
    a_force_kept: assert property (sync_filter_force |=> sync_filter_force)
        else $error("filter force dropped without reset");
endmodule // lpc_link_ctrl_monitor

bind lpc_link_ctrl lpc_link_ctrl_monitor u_lpc_link_ctrl_monitor (.*);

// file: tb/lpc_link_ctrl_tb_top.sv
/* Bench for lpc_link_ctrl: set/clear accesses over AXI4-Lite and timer pins.
   Assumes the design's synchronous active low reset and a 20 MHz clock. */
`timescale 1ns/1ps
module lpc_link_ctrl_tb_top;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, offset_clk_tick;
    logic external_cycle_input, overlong_cycle_event, rx_cycle_start, cycle_rollover, cycle_start_request;
    logic async_receive_request_enable, phy_packet_store_enable, self_id_accept, sync_filter_force;
    logic [11:0] s_axi_awaddr, s_axi_araddr, rx_cycle_offset, cycle_offset, held;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, tag_one_sync_filter_sw, tag_one_sync_filter;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic ta, tw, tr, tb;
    int failures, checks, n;

    lpc_link_ctrl u_lpc_link_ctrl (.*);

    // Free running clock
    initial
    begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // Compare seen against expected
    task chk(input logic [31:0] s, input logic [31:0] e);
        begin
            checks++;
            if (s !== e)
            begin
                failures++;
                $display("mismatch at %0t seen %h expected %h", $time, s, e);
            end
        end
    endtask

    // Verdict and stop
    task end_of_test;
        begin
            $display("checks %0d failures %0d", checks, failures);
            if (failures == 0 && checks > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    // One access, d is write data or expected read data; sampled at negedge
    // so the ready seen is the value the next rising edge takes
    task acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        begin
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_araddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= w;
            s_axi_wvalid <= w;
            s_axi_bready <= w;
            s_axi_arvalid <= !w;
            s_axi_rready <= !w;
            n = 0;
            do
            begin
                @(negedge aclk);
                n++;
                ta = s_axi_awvalid && s_axi_awready;
                tw = s_axi_wvalid && s_axi_wready;
                tr = s_axi_arvalid && s_axi_arready;
                tb = w ? s_axi_bvalid : s_axi_rvalid;
                if (tb) chk(w ? s_axi_bresp : s_axi_rresp, er);
                if (tb && !w) chk(s_axi_rdata, d);
                @(posedge aclk);
                if (ta) s_axi_awvalid <= 1'b0;
                if (tw) s_axi_wvalid <= 1'b0;
                if (tr) s_axi_arvalid <= 1'b0;
            end
            while (!tb);
            s_axi_bready <= 1'b0;
            s_axi_rready <= 1'b0;
        end
    endtask

    // Reset for five edges, then settle
    task rst;
        begin
            aresetn <= 1'b0;
            repeat (5) @(posedge aclk);
            aresetn <= 1'b1;
            repeat (2) @(posedge aclk);
        end
    endtask

    // Cycles until the next rollover pulse, bounded
    task wroll;
        begin
            n = 0;
            do
            begin
                @(negedge aclk);
                n++;
            end
            while (!cycle_rollover && n < 4000);
        end
    endtask

    // Hang guard, well above the two 3072-cycle waits
    initial
    begin
        #1_000_000;
        failures++;
        end_of_test();
    end

    // Main sequence
    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {offset_clk_tick, external_cycle_input, overlong_cycle_event, rx_cycle_start} = '0;
        {async_receive_request_enable, s_axi_awaddr, s_axi_araddr, s_axi_wdata, rx_cycle_offset} = '0;
        tag_one_sync_filter_sw = 4'h0;
        s_axi_wstrb = 4'hf;
        rst();
        acc(0, 12'h0e0, 32'h0000_0000, 2'h0);
        async_receive_request_enable <= 1'b1;
        acc(1, 12'h0e0, 32'hffff_ffff, 2'h0);
        acc(0, 12'h0e4, 32'h0070_0640, 2'h0);
        @(negedge aclk);
        chk(phy_packet_store_enable, 1'b1);
        chk(self_id_accept, 1'b1);
        chk(tag_one_sync_filter, 4'hf);
        @(posedge aclk);
        async_receive_request_enable <= 1'b0;
        @(negedge aclk);
        chk(phy_packet_store_enable, 1'b0);
        acc(1, 12'h0e4, 32'hffff_ffff, 2'h0);
        acc(0, 12'h0e0, 32'h0000_0040, 2'h0);
        acc(1, 12'h0e0, 32'h0000_0000, 2'h0);
        acc(1, 12'h0f0, 32'hffff_ffff, 2'h3);
        acc(0, 12'h0e4, 32'h0000_0040, 2'h0);
        acc(0, 12'h100, 32'h0000_0000, 2'h3);
        tag_one_sync_filter_sw <= 4'h5;
        overlong_cycle_event <= 1'b1;
        rst();
        @(negedge aclk);
        chk(sync_filter_force, 1'b0);
        chk(tag_one_sync_filter, 4'h5);
        acc(1, 12'h0e0, 32'h0020_0000, 2'h0);
        acc(0, 12'h0e0, 32'h0000_0000, 2'h0);
        overlong_cycle_event <= 1'b0;
        acc(1, 12'h0e0, 32'h0030_0000, 2'h0);
        offset_clk_tick <= 1'b1;
        wroll();
        wroll();
        chk(n, 3072);
        chk(cycle_start_request, 1'b1);
        @(posedge aclk);
        overlong_cycle_event <= 1'b1;
        repeat (4) @(posedge aclk);
        overlong_cycle_event <= 1'b0;
        acc(0, 12'h0e0, 32'h0010_0000, 2'h0);
        acc(1, 12'h0e4, 32'h0010_0000, 2'h0);
        @(negedge aclk);
        held = cycle_offset;
        repeat (20) @(negedge aclk);
        chk(cycle_offset, held);
        @(posedge aclk);
        rx_cycle_offset <= 12'h123;
        rx_cycle_start <= 1'b1;
        @(posedge aclk);
        rx_cycle_start <= 1'b0;
        @(negedge aclk);
        chk(cycle_offset, 12'h123);
        acc(0, 12'h0f0, 32'h0000_0123, 2'h0);
        s_axi_wstrb <= 4'h2;
        acc(1, 12'h0e0, 32'hffff_ffff, 2'h0);
        s_axi_wstrb <= 4'hf;
        acc(0, 12'h0e0, 32'h0000_0600, 2'h0);
        acc(1, 12'h0e0, 32'h0040_0000, 2'h0);
        external_cycle_input <= 1'b1;
        wroll();
        chk(cycle_rollover, 1'b1);
        chk(cycle_offset, 12'h000);
        chk(cycle_start_request, 1'b0);
        acc(0, 12'h0f0, 32'h0002_0000, 2'h0);
        end_of_test();
    end
endmodule // lpc_link_ctrl_tb_top
